// ===== scc_pkg.sv
/*
 strap_config_capture package: encodings, strap defaults and timing counts.
 assumes the 100 MHz core clock.
*/
`default_nettype none
package scc_pkg;
   // ------------------------------------------------------------
   // port-5 role
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SCC_ROLE_OFF,
      SCC_ROLE_PHY_MII,
      SCC_ROLE_MAC_MII,
      SCC_ROLE_PHY_SNI
   } scc_role_e;
   localparam logic [2:0] SCC_ROLE_SEL_TRI = 3'h0;
   localparam logic [2:0] SCC_ROLE_SEL_DEF = 3'h4;
   // ------------------------------------------------------------
   // management bus select
   // ------------------------------------------------------------
   localparam logic [1:0] SCC_BUS_I2C  = 2'h0;
   localparam logic [1:0] SCC_BUS_SMI  = 2'h1;
   localparam logic [1:0] SCC_BUS_SPI  = 2'h2;
   localparam logic [1:0] SCC_BUS_BIST = 2'h3;
   // ------------------------------------------------------------
   // register field images loaded from straps
   // ------------------------------------------------------------
   localparam int         SCC_R76_AN_BIT   = 7;
   localparam int         SCC_R14_ED_LSB   = 3;
   localparam logic [1:0] SCC_R14_NORMAL   = 2'h0;
   localparam logic [1:0] SCC_R14_ENERGY_DETECT_POWERDOWN     = 2'h3;
   localparam int         SCC_R132_DS_LSB  = 6;
   localparam logic [1:0] SCC_R132_8MA     = 2'h0;
   localparam logic [1:0] SCC_R132_12MA    = 2'h2;
   localparam int         SCC_R60_AN_BIT   = 7;
   localparam int         SCC_R60_DUP_BIT  = 5;
   localparam int         SCC_R60_FC_BIT   = 4;
   // ------------------------------------------------------------
   // frame size limits (bytes)
   // ------------------------------------------------------------
   localparam logic [10:0] SCC_FRAME_STD    = 11'h5F2;
   localparam logic [10:0] SCC_FRAME_LONG   = 11'h600;
   // ------------------------------------------------------------
   // strap pin defaults (level of internal pull)
   // ------------------------------------------------------------
   localparam logic SCC_PULL_DOWN = 1'b0;
   localparam logic SCC_PULL_UP   = 1'b1;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int SCC_CLK_MHZ      = 100;
   localparam int SCC_I2C_CLK_HZ   = 61000;
   localparam int SCC_I2C_HALF_CYC =
      (SCC_CLK_MHZ * 1000000) / (2 * SCC_I2C_CLK_HZ);
   localparam int SCC_SPI_MAX_MHZ  = 25;
endpackage
`default_nettype wire

// ===== scc_clkdiv_if.sv
/*
 interface between the strap capture top and the serial clock divider.
 assumes one shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface scc_clkdiv_if;
   logic run;
   logic tick;
   modport ctrl (output run, input tick);
   modport div  (input run, output tick);
endinterface
`default_nettype wire

// ===== scc_clkdiv.sv
/*
 half-period divider for the serial master clock.
 assumes a clock enable gated by the owner.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_clkdiv
   import scc_pkg::*;
#(
   parameter int HALF_CYC = SCC_I2C_HALF_CYC
)
(
   // clock and reset
   input  wire logic   i_clock,
   input  wire logic   i_rst_n,
   input  wire logic   i_clk_en,
   // control
   scc_clkdiv_if.div   bus
);
   // the counter is 16 bits wide, so longer half periods cannot be served
   if (HALF_CYC < 1 || HALF_CYC > 65535)
      $error("scc_clkdiv: HALF_CYC out of range");

   logic [15:0] cnt_q;
   logic        tick_q;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         cnt_q  <= 16'h0;
         tick_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         tick_q <= 1'b0;
         if (!bus.run)
            cnt_q <= 16'h0;
         else if (cnt_q == 16'(HALF_CYC - 1))
         begin
            cnt_q  <= 16'h0;
            tick_q <= 1'b1;
         end
         else
            cnt_q <= cnt_q + 16'h1;
      end
   end

   assign bus.tick = tick_q;
endmodule
`default_nettype wire

// ===== scc_top.sv
/*
 strap_config_capture: samples dual-purpose strap pins at the release of
 reset and drives the configuration they select, plus the pin direction
 control for those pins once reset is over.
 assumes strap pins synchronous to i_clock; pull resistors on the board.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_top
   import scc_pkg::*;
#(
   parameter int I2C_HALF_CYC = SCC_I2C_HALF_CYC
)
(
   // clock, reset, enable
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_clk_en,
   // port-5 role and link straps
   input  wire logic        i_p5_role_sel_hi,
   input  wire logic        i_p5_role_sel_lo,
   input  wire logic        i_phy_five_if_strap,
   input  wire logic        i_p5_rx_bit3_fc_strap,
   input  wire logic        i_p5_rx_bit2_duplex_strap,
   input  wire logic        i_p5_rx_bit1_speed_strap,
   input  wire logic        i_p5_rx_bit0_led_strap,
   // switch and port straps
   input  wire logic        i_aging_strap,
   input  wire logic        i_port4_autoneg_strap,
   input  wire logic        i_energy_detect_strap,
   input  wire logic        i_drive_strength_strap,
   input  wire logic        i_port3_autoneg_strap,
   input  wire logic        i_port3_force_fc_strap,
   input  wire logic        i_port3_duplex_strap,
   input  wire logic        i_legacy_fc_strap,
   input  wire logic        i_legacy_backpressure_strap,
   input  wire logic        i_legacy_collision_drop_strap,
   input  wire logic        i_legacy_backoff_strap,
   input  wire logic        i_frame_size_strap,
   input  wire logic        i_bus_sel_hi,
   input  wire logic        i_bus_sel_lo,
   // runtime status in
   input  wire logic        i_eeprom_absent,
   input  wire logic        i_chip_select_n,
   input  wire logic        i_link_up,
   input  wire logic        i_link_100,
   input  wire logic        i_link_full,
   input  wire logic        i_activity,
   input  wire logic        i_collision,
   // strap pin direction
   output logic             o_strap_pins_oe,
   output logic             o_strap_pull_en,
   // port-5 role and pin directions
   output logic [1:0]       o_p5_role,
   output logic             o_p5_enable,
   output logic             o_p5_tristate,
   output logic             o_p5_tx_clock_oe,
   output logic             o_p5_rx_clock_oe,
   output logic             o_p5_collision_oe,
   output logic             o_p5_carrier_sense_oe,
   // port-5 link configuration
   output logic             o_p5_fc_en,
   output logic             o_p5_half_duplex,
   output logic             o_p5_speed_10,
   output logic             o_led_mode,
   output logic [2:0]       o_led_code,
   // switch and port configuration
   output logic             o_aging_en,
   output logic [7:0]       o_reg76_image,
   output logic [7:0]       o_reg14_image,
   output logic [7:0]       o_reg132_image,
   output logic [7:0]       o_reg60_image,
   output logic             o_legacy_fc_en,
   output logic             o_legacy_backpressure_en,
   output logic             o_legacy_collision_drop,
   output logic             o_legacy_backoff_en,
   output logic [10:0]      o_max_frame_len,
   // management bus
   output logic [1:0]       o_bus_sel,
   output logic             o_use_default_regs,
   output logic             o_serial_out_oe,
   output logic             o_serial_clock_pin_o,
   output logic             o_serial_clock_pin_oe
);
   if (I2C_HALF_CYC < 1)
      $error("scc_top: I2C_HALF_CYC must be positive");

   // ------------------------------------------------------------
   // reset release detection
   // ------------------------------------------------------------
   // the latch happens on the first enabled edge with reset high, so
   // a held-low enable simply postpones the capture.
   logic captured_q;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         captured_q <= 1'b0;
      else if (i_clk_en)
         captured_q <= 1'b1;
   end

   wire logic capture_now = i_clk_en && !captured_q;

   // ------------------------------------------------------------
   // pin direction of strap pins
   // ------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_strap_pins_oe <= 1'b0;
         o_strap_pull_en <= 1'b1;
      end
      else if (capture_now)
      begin
         o_strap_pins_oe <= 1'b1;
         o_strap_pull_en <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // strap latch
   // ------------------------------------------------------------
   // held values show the defaults until the capture edge, so the
   // device runs from defaults with nothing strapped.
   logic [2:0] role_sel_q;
   logic       five_if_q;
   logic       fc_q, dup_q, spd_q, led_q;
   logic       aging_q, p4an_q, ed_q, ds_q;
   logic       p3an_q, p3fc_q, p3dup_q;
   logic       lfc_q, lbp_q, lcd_q, lbo_q, frame_q;
   logic [1:0] bus_q;

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         role_sel_q <= SCC_ROLE_SEL_DEF;
         five_if_q  <= SCC_PULL_UP;
         fc_q       <= SCC_PULL_DOWN;
         dup_q      <= SCC_PULL_DOWN;
         spd_q      <= SCC_PULL_DOWN;
         led_q      <= SCC_PULL_DOWN;
         aging_q    <= SCC_PULL_UP;
         p4an_q     <= SCC_PULL_UP;
         ed_q       <= SCC_PULL_UP;
         ds_q       <= SCC_PULL_UP;
         p3an_q     <= SCC_PULL_UP;
         p3fc_q     <= SCC_PULL_UP;
         p3dup_q    <= SCC_PULL_UP;
         lfc_q      <= SCC_PULL_DOWN;
         lbp_q      <= SCC_PULL_DOWN;
         lcd_q      <= SCC_PULL_DOWN;
         lbo_q      <= SCC_PULL_DOWN;
         frame_q    <= SCC_PULL_DOWN;
         bus_q      <= SCC_BUS_I2C;
      end
      else if (capture_now)
      begin
         role_sel_q <= {i_phy_five_if_strap, i_p5_role_sel_hi,
                        i_p5_role_sel_lo};
         five_if_q  <= i_phy_five_if_strap;
         fc_q       <= i_p5_rx_bit3_fc_strap;
         dup_q      <= i_p5_rx_bit2_duplex_strap;
         spd_q      <= i_p5_rx_bit1_speed_strap;
         led_q      <= i_p5_rx_bit0_led_strap;
         aging_q    <= i_aging_strap;
         p4an_q     <= i_port4_autoneg_strap;
         ed_q       <= i_energy_detect_strap;
         ds_q       <= i_drive_strength_strap;
         p3an_q     <= i_port3_autoneg_strap;
         p3fc_q     <= i_port3_force_fc_strap;
         p3dup_q    <= i_port3_duplex_strap;
         lfc_q      <= i_legacy_fc_strap;
         lbp_q      <= i_legacy_backpressure_strap;
         lcd_q      <= i_legacy_collision_drop_strap;
         lbo_q      <= i_legacy_backoff_strap;
         frame_q    <= i_frame_size_strap;
         bus_q      <= {i_bus_sel_hi, i_bus_sel_lo};
      end
   end

   // ------------------------------------------------------------
   // port-5 role decode
   // ------------------------------------------------------------
   scc_role_e role_d;
   logic      is_phy, is_mac;

   always_comb
   begin
      case (role_sel_q[1:0])
         2'h1:    role_d = SCC_ROLE_PHY_MII;
         2'h2:    role_d = SCC_ROLE_MAC_MII;
         2'h3:    role_d = SCC_ROLE_PHY_SNI;
         default: role_d = SCC_ROLE_OFF;
      endcase
      if (!five_if_q)
         role_d = SCC_ROLE_OFF;
      is_phy = (role_d == SCC_ROLE_PHY_MII) ||
               (role_d == SCC_ROLE_PHY_SNI);
      is_mac = (role_d == SCC_ROLE_MAC_MII);
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_p5_role             <= SCC_ROLE_OFF;
         o_p5_enable           <= 1'b0;
         o_p5_tristate         <= 1'b1;
         o_p5_tx_clock_oe      <= 1'b0;
         o_p5_rx_clock_oe      <= 1'b0;
         o_p5_collision_oe     <= 1'b0;
         o_p5_carrier_sense_oe <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_p5_role     <= role_d;
         o_p5_enable   <= is_phy || is_mac;
         o_p5_tristate <= (role_sel_q == SCC_ROLE_SEL_TRI) ||
                          !five_if_q;
         // in MAC role the PHY partner owns these pins, so never fight it
         o_p5_tx_clock_oe      <= is_phy;
         o_p5_rx_clock_oe      <= is_phy;
         o_p5_collision_oe     <= is_phy;
         o_p5_carrier_sense_oe <= is_phy;
      end
   end

   // ------------------------------------------------------------
   // link configuration and LEDs
   // ------------------------------------------------------------
   logic [2:0] led_d;

   always_comb
   begin
      led_d = 3'h0;
      if (!led_q)
      begin
         // mode 0: link/act, duplex/col, speed
         led_d[2] = !(i_link_up && !i_activity);
         led_d[1] = !i_link_full || i_collision;
         led_d[0] = !i_link_100;
         if (i_link_up && !i_activity)
            led_d[2] = 1'b0;
      end
      else
      begin
         // mode 1: 100 link, 10 link, full duplex; activity is not shown
         led_d[2] = !(i_link_up && i_link_100);
         led_d[1] = !(i_link_up && !i_link_100);
         led_d[0] = !(i_link_up && i_link_full);
      end
      if (!i_link_up)
         led_d = 3'h7;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_p5_fc_en       <= 1'b0;
         o_p5_half_duplex <= 1'b0;
         o_p5_speed_10    <= 1'b0;
         o_led_mode       <= 1'b0;
         o_led_code       <= 3'h7;
      end
      else if (i_clk_en)
      begin
         o_p5_fc_en       <= fc_q;
         o_p5_half_duplex <= dup_q;
         o_p5_speed_10    <= spd_q;
         o_led_mode       <= led_q;
         o_led_code       <= led_d;
      end
   end

   // ------------------------------------------------------------
   // switch-wide and per-port defaults
   // ------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_aging_en               <= 1'b1;
         o_reg76_image            <= 8'h0;
         o_reg14_image            <= 8'h0;
         o_reg132_image           <= 8'h0;
         o_reg60_image            <= 8'h0;
         o_legacy_fc_en           <= 1'b1;
         o_legacy_backpressure_en <= 1'b0;
         o_legacy_collision_drop  <= 1'b1;
         o_legacy_backoff_en      <= 1'b0;
         o_max_frame_len          <= SCC_FRAME_STD;
      end
      else if (i_clk_en)
      begin
         o_aging_en <= aging_q;
         o_reg76_image <= 8'h0;
         o_reg76_image[SCC_R76_AN_BIT] <= p4an_q;
         o_reg14_image <= 8'h0;
         o_reg14_image[SCC_R14_ED_LSB +: 2] <=
            ed_q ? SCC_R14_NORMAL : SCC_R14_ENERGY_DETECT_POWERDOWN;
         o_reg132_image <= 8'h0;
         o_reg132_image[SCC_R132_DS_LSB +: 2] <=
            ds_q ? SCC_R132_8MA : SCC_R132_12MA;
         o_reg60_image <= 8'h0;
         o_reg60_image[SCC_R60_AN_BIT]  <= p3an_q;
         o_reg60_image[SCC_R60_DUP_BIT] <= !p3dup_q;
         o_reg60_image[SCC_R60_FC_BIT]  <= !p3fc_q;
         o_legacy_fc_en           <= !lfc_q;
         o_legacy_backpressure_en <= lbp_q;
         o_legacy_collision_drop  <= !lcd_q;
         o_legacy_backoff_en      <= lbo_q;
         o_max_frame_len <= frame_q ? SCC_FRAME_LONG
                                    : SCC_FRAME_STD;
      end
   end

   // ------------------------------------------------------------
   // management bus
   // ------------------------------------------------------------
   scc_clkdiv_if div_bus ();
   logic         scl_q;

   assign div_bus.run = captured_q && (bus_q == SCC_BUS_I2C);

   scc_clkdiv #(
      .HALF_CYC (I2C_HALF_CYC)
   ) u_div (
      .i_clock  (i_clock),
      .i_rst_n  (i_rst_n),
      .i_clk_en (i_clk_en),
      .bus      (div_bus)
   );

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         scl_q <= 1'b1;
      else if (i_clk_en && div_bus.tick)
         scl_q <= !scl_q;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         o_bus_sel             <= SCC_BUS_I2C;
         o_use_default_regs    <= 1'b1;
         o_serial_out_oe       <= 1'b0;
         o_serial_clock_pin_o  <= 1'b1;
         o_serial_clock_pin_oe <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_bus_sel <= bus_q;
         // defaults are flagged only with the I2C bus selected and the EEPROM absent
         o_use_default_regs <= (bus_q == SCC_BUS_I2C) &&
                               i_eeprom_absent;
         o_serial_out_oe <= (bus_q == SCC_BUS_SPI) &&
                            !i_chip_select_n;
         o_serial_clock_pin_o  <= scl_q;
         o_serial_clock_pin_oe <= captured_q &&
                                  (bus_q == SCC_BUS_I2C);
      end
   end
endmodule
`default_nettype wire

// ===== scc_board.sv
/*
 scc_board: board pull resistors on the dual-purpose strap pins.
 assumes the direction flag is high once the pins turn to outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_board
(
   // pull levels and device pin direction
   input  wire logic [20:0] i_pull,
   input  wire logic        i_pins_oe,
   // level seen at the strap inputs
   output logic      [20:0] o_strap
);
   // pulls only hold the level while the pins are inputs; afterwards show
   // the inverse so that a late sample cannot pass unnoticed
   assign o_strap = i_pins_oe ? ~i_pull : i_pull;
endmodule
`default_nettype wire

// ===== scc_top_monitor.sv
/*
 checker on scc_top ports: capture moment, role and bus decode, pin
 directions. assumes a bind from the bench and steady straps at release.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_top_monitor
   import scc_pkg::*;
#(
   parameter int I2C_HALF_CYC = SCC_I2C_HALF_CYC
)
(
   // clock, reset, inputs
   input wire logic       i_clock,
   input wire logic       i_rst_n,
   input wire logic       i_clk_en,
   input wire logic       i_phy_five_if_strap,
   input wire logic       i_p5_role_sel_hi,
   input wire logic       i_p5_role_sel_lo,
   input wire logic       i_bus_sel_hi,
   input wire logic       i_bus_sel_lo,
   input wire logic       i_eeprom_absent,
   input wire logic       i_chip_select_n,
   // outputs watched
   input wire logic       o_strap_pins_oe,
   input wire logic       o_strap_pull_en,
   input wire logic [1:0] o_p5_role,
   input wire logic       o_p5_tx_clock_oe,
   input wire logic       o_p5_collision_oe,
   input wire logic [1:0] o_bus_sel,
   input wire logic       o_use_default_regs,
   input wire logic       o_serial_out_oe,
   input wire logic       o_serial_clock_pin_o,
   input wire logic       o_serial_clock_pin_oe
);
   logic [2:0] rc_q;
   logic [7:0] hc_q;
   logic       sn_q;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // enabled edges since release, saturating; capture is the first
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         rc_q <= 3'h0;
      else if (i_clk_en && rc_q != 3'h7)
         rc_q <= rc_q + 3'h1;
   end
   // cycles the serial clock has stood still, counted from its first
   // toggle: the divider start-up delays that toggle by two cycles
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n || !i_clk_en || !o_serial_clock_pin_oe)
      begin
         hc_q <= 8'h0;
         sn_q <= 1'b0;
      end
      else if ($changed(o_serial_clock_pin_o))
      begin
         hc_q <= 8'h0;
         sn_q <= 1'b1;
      end
      else if (sn_q)
         hc_q <= hc_q + 8'h1;
   end
   capture_oe_a: assert property (rc_q == 3'h1 |->
      o_strap_pins_oe && !o_strap_pull_en) else $error("pins not turned");
   pull_inverse_a: assert property (o_strap_pull_en != o_strap_pins_oe)
      else $error("pull and drive overlap");
   role_decode_a: assert property (rc_q == 3'h2 &&
      $past(i_phy_five_if_strap, 2) |-> o_p5_role ==
      {$past(i_p5_role_sel_hi, 2), $past(i_p5_role_sel_lo, 2)})
      else $error("role decode wrong");
   phy_pins_a: assert property (o_p5_tx_clock_oe == o_p5_role[0] &&
      o_p5_collision_oe == o_p5_role[0]) else $error("pin direction wrong");
   bus_sel_a: assert property (rc_q == 3'h2 |-> o_bus_sel ==
      {$past(i_bus_sel_hi, 2), $past(i_bus_sel_lo, 2)})
      else $error("bus select wrong");
   config_hold_a: assert property (rc_q == 3'h7 |-> $stable(o_p5_role) &&
      $stable(o_bus_sel) && o_strap_pins_oe) else $error("config moved");
   eeprom_default_a: assert property (rc_q == 3'h7 && $past(i_clk_en) |->
      o_use_default_regs == (o_bus_sel == SCC_BUS_I2C && $past(i_eeprom_absent)))
      else $error("default register flag wrong");
   spi_release_a: assert property ($past(i_chip_select_n) &&
      $past(i_clk_en) |-> !o_serial_out_oe) else $error("serial out driven");
   scl_period_a: assert property (hc_q < I2C_HALF_CYC)
      else $error("serial clock stalled");
endmodule
`default_nettype wire

// ===== scc_top_tb.sv
/*
 scc_top_tb: self-checking bench for the strap capture block.
 assumes scc_board and scc_top_monitor are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_top_tb
   import scc_pkg::*;
;
   localparam int          HC  = 4;
   localparam logic [20:0] DEF = 21'h103F80;
   logic        i_clock = 1'h0, i_rst_n = 1'h0, i_clk_en = 1'h1;
   logic        i_eeprom_absent = 1'h0, i_chip_select_n = 1'h1;
   logic        i_link_up = 1'h0, i_link_100 = 1'h0, i_link_full = 1'h0;
   logic        i_activity = 1'h0, i_collision = 1'h0;
   logic [20:0] pull = DEF, st;
   logic        o_strap_pins_oe, o_strap_pull_en, o_p5_enable, o_p5_tristate;
   logic        o_p5_tx_clock_oe, o_p5_rx_clock_oe, o_p5_collision_oe;
   logic        o_p5_carrier_sense_oe, o_p5_fc_en, o_p5_half_duplex;
   logic        o_p5_speed_10, o_led_mode, o_aging_en, o_legacy_fc_en;
   logic        o_legacy_backpressure_en, o_legacy_collision_drop;
   logic        o_legacy_backoff_en, o_use_default_regs, o_serial_out_oe;
   logic        o_serial_clock_pin_o, o_serial_clock_pin_oe;
   logic [1:0]  o_p5_role, o_bus_sel;
   logic [2:0]  o_led_code;
   logic [7:0]  o_reg76_image, o_reg14_image, o_reg132_image, o_reg60_image;
   logic [10:0] o_max_frame_len;
   int          fails = 0, cmp_count = 0;
   always #5 i_clock = ~i_clock;
   scc_board board (.i_pull(pull), .i_pins_oe(o_strap_pins_oe), .o_strap(st));
   scc_top #(.I2C_HALF_CYC(HC)) DUT (
      .i_clock, .i_rst_n, .i_clk_en,
      .i_phy_five_if_strap(st[20]), .i_p5_role_sel_hi(st[19]),
      .i_p5_role_sel_lo(st[18]), .i_p5_rx_bit3_fc_strap(st[17]),
      .i_p5_rx_bit2_duplex_strap(st[16]), .i_p5_rx_bit1_speed_strap(st[15]),
      .i_p5_rx_bit0_led_strap(st[14]), .i_aging_strap(st[13]),
      .i_port4_autoneg_strap(st[12]), .i_energy_detect_strap(st[11]),
      .i_drive_strength_strap(st[10]), .i_port3_autoneg_strap(st[9]),
      .i_port3_force_fc_strap(st[8]), .i_port3_duplex_strap(st[7]),
      .i_legacy_fc_strap(st[6]), .i_legacy_backpressure_strap(st[5]),
      .i_legacy_collision_drop_strap(st[4]), .i_legacy_backoff_strap(st[3]),
      .i_frame_size_strap(st[2]), .i_bus_sel_hi(st[1]), .i_bus_sel_lo(st[0]),
      .i_eeprom_absent, .i_chip_select_n, .i_link_up, .i_link_100,
      .i_link_full, .i_activity, .i_collision, .o_strap_pins_oe,
      .o_strap_pull_en, .o_p5_role, .o_p5_enable, .o_p5_tristate,
      .o_p5_tx_clock_oe, .o_p5_rx_clock_oe, .o_p5_collision_oe,
      .o_p5_carrier_sense_oe, .o_p5_fc_en, .o_p5_half_duplex, .o_p5_speed_10,
      .o_led_mode, .o_led_code, .o_aging_en, .o_reg76_image, .o_reg14_image,
      .o_reg132_image, .o_reg60_image, .o_legacy_fc_en,
      .o_legacy_backpressure_en, .o_legacy_collision_drop,
      .o_legacy_backoff_en, .o_max_frame_len, .o_bus_sel,
      .o_use_default_regs, .o_serial_out_oe, .o_serial_clock_pin_o,
      .o_serial_clock_pin_oe
   );
   task automatic step(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic chk(input string nm, input logic [10:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_reset(input logic [20:0] p);
      i_rst_n = 1'h0;
      pull = p;
      step(3);
      chk("pins_oe", 1'h0, o_strap_pins_oe);
      chk("pull_en", 1'h1, o_strap_pull_en);
      i_rst_n = 1'h1;
      step(3);
   endtask
   task automatic t_cfg(input logic [20:0] p);
      logic [1:0] r;
      r = p[20] ? p[19:18] : 2'h0;
      chk("pins_oe", 1'h1, o_strap_pins_oe);
      chk("role", r, o_p5_role);
      chk("enable", r != 2'h0, o_p5_enable);
      chk("tristate", !p[20], o_p5_tristate);
      chk("clk_oe", {2{r[0]}}, {o_p5_tx_clock_oe, o_p5_rx_clock_oe});
      chk("col_oe", {2{r[0]}}, {o_p5_collision_oe, o_p5_carrier_sense_oe});
      chk("fc", p[17], o_p5_fc_en);
      chk("half", p[16], o_p5_half_duplex);
      chk("speed10", p[15], o_p5_speed_10);
      chk("led_mode", p[14], o_led_mode);
      chk("aging", p[13], o_aging_en);
      chk("reg76", {p[12], 7'h0}, o_reg76_image);
      chk("reg14", p[11] ? 8'h0 : 8'h18, o_reg14_image);
      chk("reg132", p[10] ? 8'h0 : 8'h80, o_reg132_image);
      chk("reg60", {p[9], 1'h0, !p[7], !p[8], 4'h0}, o_reg60_image);
      chk("leg_a", {!p[6], p[5]}, {o_legacy_fc_en, o_legacy_backpressure_en});
      chk("leg_b", {!p[4], p[3]}, {o_legacy_collision_drop, o_legacy_backoff_en});
      chk("frame", p[2] ? SCC_FRAME_LONG : SCC_FRAME_STD, o_max_frame_len);
      chk("bus", p[1:0], o_bus_sel);
   endtask
   task automatic t_roles;
      logic [20:0] p;
      for (int i = 0; i < 5; i++)
      begin
         p = i[0] ? ~DEF : DEF;
         p[20:18] = (i < 4) ? {1'h1, i[1:0]} : 3'h0;
         p[1:0] = i[1:0];
         t_reset(p);
         t_cfg(p);
         chk("scl_oe", i[1:0] == 2'h0, o_serial_clock_pin_oe);
         i_eeprom_absent = 1'h1;
         step(2);
         chk("use_def", i[1:0] == 2'h0, o_use_default_regs);
         chk("sout_oe", 1'h0, o_serial_out_oe);
         i_chip_select_n = 1'h0; // transfer opens on a falling select
         i_eeprom_absent = 1'h0;
         step(2);
         chk("sout_oe", i[1:0] == 2'h2, o_serial_out_oe);
         chk("use_def", 1'h0, o_use_default_regs);
         i_chip_select_n = 1'h1;
      end
   endtask
   task automatic t_hold;
      logic [20:0] p;
      p = ~DEF;
      p[20] = 1'h1;
      i_rst_n = 1'h0;
      pull = p;
      step(3);
      i_clk_en = 1'h0;
      i_rst_n = 1'h1;
      step(5);
      chk("pins_oe", 1'h0, o_strap_pins_oe);
      i_clk_en = 1'h1;
      step(10);
      t_cfg(p);
   endtask
   task automatic t_led;
      for (int m = 0; m < 2; m++)
      begin
         t_reset(m[0] ? DEF | 21'h4000 : DEF);
         i_link_up = 1'h1;
         for (int k = 0; k < 4; k++)
         begin
            {i_link_100, i_link_full} = k[1:0];
            step(2);
            if (m == 0)
               chk("led", {1'h0, !k[0], !k[1]}, o_led_code);
            else
               chk("led1", {!k[1], k[1], !k[0]}, o_led_code);
         end
         i_link_up = 1'h0;
         step(2);
         chk("led_down", 3'h7, o_led_code);
      end
   endtask
   task automatic t_scl;
      logic v;
      int   n;
      t_reset(DEF);
      chk("scl_oe", 1'h1, o_serial_clock_pin_oe);
      for (int j = 0; j < 2; j++)
      begin
         v = o_serial_clock_pin_o;
         n = 0;
         while (o_serial_clock_pin_o === v && n < 20)
         begin
            step(1);
            n++;
         end
      end
      chk("scl_half", 11'(HC), 11'(n));
   endtask
   initial
   begin
      t_roles;
      t_hold;
      t_led;
      t_scl;
      end_sim;
   end
   // the whole run needs well under 1000 cycles
   initial
   begin
      #100000;
      fails++;
      end_sim;
   end
endmodule
bind scc_top scc_top_monitor #(.I2C_HALF_CYC(I2C_HALF_CYC)) mon (
   .i_clock, .i_rst_n, .i_clk_en, .i_phy_five_if_strap,
   .i_p5_role_sel_hi, .i_p5_role_sel_lo, .i_bus_sel_hi, .i_bus_sel_lo,
   .i_eeprom_absent, .i_chip_select_n, .o_strap_pins_oe, .o_strap_pull_en,
   .o_p5_role, .o_p5_tx_clock_oe, .o_p5_collision_oe, .o_bus_sel,
   .o_use_default_regs, .o_serial_out_oe, .o_serial_clock_pin_o,
   .o_serial_clock_pin_oe
);
`default_nettype wire
